// ===== core/pws_top.sv
`timescale 1ns/10ps
// Functional notes
// R1 - any reset makes all port pins inputs and resets unit registers
// R2 - software first sets the pwm pin direction bit to input
// R3 - software then writes the cycle length into the period register
// R4 - software then selects pwm mode in the unit control register
// R5 - software writes duty upper byte and two low bits in control
// R6 - software clears the period match flag before starting the timer
// R7 - software selects prescale, then sets the timer run bit
// R8 - software enables the pin driver after the match flag sets
// R9 - control: duty low bits 5:4, mode 3:0, bits 7:6 read zero
// R10 - duty bytes unknown at power-on, kept through other resets
// R11 - timer control: postscale 6:3, run 2, prescale 1:0, bit 7 zero
// R12 - wide timer control clears at power-on only, kept otherwise
// R13 - wide timer bytes unknown at power-on, kept otherwise
// R14 - period timer count clears on other resets
// R15 - port direction registers reset to all ones on every reset
// R16 - flag/enable: unit one bit 2, match bit 1, unit two bit 0
// R17 - on match the timer clears, pin sets unless duty zero, duty shadows
// R18 - pin clears when ten-bit time base equals shadowed duty
// R19 - pin stays undriven while its direction bit selects input
module pws_top
  import pws_pkg::*;
#(
  parameter int unsigned PWM_PIN_BIT = 2
) (
  // clock, resets and enable
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic npor_i,
  input wire logic ce_i,
  // register port
  input wire logic [4:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // pins
  output logic pwm_pin_o,
  output logic pwm_pin_oe_o,
  output logic [7:0] port_c_oe_o,
  output logic [7:0] port_d_oe_o,
  // interrupt
  output logic irq_o
);

  // state set to its reset values by any reset
  typedef struct packed {
    logic [5:0] unit_ctrl;
    logic [7:0] period_reg;
    logic [6:0] t2_ctrl;
    logic [7:0] t2_count;
    logic [3:0] post_cnt;
    logic [7:0] flags_one;
    logic [7:0] enable_one;
    logic [7:0] flags_two;
    logic [7:0] enable_two;
    logic [7:0] dir_c;
    logic [7:0] dir_d;
    logic [7:0] int_ctrl;
    logic [1:0] cmp_ctrl;
    logic [7:0] rdata;
  } pws_st_t;

  // state that no reset touches
  typedef struct packed {
    logic [7:0] duty_low;
    logic [7:0] shadow_hi;
    logic [1:0] shadow_lo;
    logic [7:0] wide_lo;
    logic [7:0] wide_hi;
  } pws_hold_t;

  pws_st_t st_ff;
  pws_st_t nxt_st;
  pws_hold_t hold_ff;
  pws_hold_t nxt_hold;
  logic [7:0] wide_ctrl_ff;
  logic [7:0] nxt_wide_ctrl;

  logic pwm_mode;
  logic pre_inc;
  logic [1:0] pre_frac;
  logic pre_clr;
  logic t2_match;
  logic reload;
  logic match_evt;
  logic duty_zero;
  logic pwm_level;
  logic wr_count;
  logic [9:0] base;
  logic [9:0] duty_shadow;

  // decode of common conditions
  assign pwm_mode = st_ff.unit_ctrl[3:MODE_HI_POS] == MODE_PWM;
  assign wr_count = reg_wr_i && (reg_addr_i == ADR_PERIOD_COUNT);
  assign pre_clr = wr_count
    || (reg_wr_i && (reg_addr_i == ADR_PERIOD_CTRL));
  assign t2_match = st_ff.t2_count == st_ff.period_reg;
  assign reload = pre_inc && t2_match && !wr_count;
  assign duty_zero = {hold_ff.duty_low,
    st_ff.unit_ctrl[5:DUTY_LO_POS]} == 10'h000;
  // next time base: the pin falls on the edge that reaches the duty
  assign base = {nxt_st.t2_count, pre_frac}; // R18
  assign duty_shadow = {hold_ff.shadow_hi, hold_ff.shadow_lo};
  assign match_evt = reload
    && (st_ff.post_cnt == st_ff.t2_ctrl[6:POST_POS]);

  // timer step source
  pws_prescaler u_pre (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .run_i(st_ff.t2_ctrl[RUN_POS]),
    .clr_i(pre_clr),
    .sel_i(st_ff.t2_ctrl[1:0]),
    .frac_o(pre_frac),
    .inc_o(pre_inc)
  );

  // waveform latch
  pws_pwm_out u_out (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .en_i(pwm_mode),
    .reload_i(reload),
    .duty_zero_i(duty_zero),
    .base_i(base),
    .duty_i(duty_shadow),
    .level_o(pwm_level)
  );

  // pin drivers follow the direction bits
  assign port_c_oe_o = ~st_ff.dir_c; // R1
  assign port_d_oe_o = ~st_ff.dir_d; // R1
  assign pwm_pin_oe_o = !st_ff.dir_c[PWM_PIN_BIT] && pwm_mode; // R19
  assign pwm_pin_o = pwm_level;
  assign reg_rdata_o = st_ff.rdata;

  // level interrupt from unmasked sticky flags
  assign irq_o = |(st_ff.flags_one & st_ff.enable_one)
    || |(st_ff.flags_two & st_ff.enable_two);

  // next state: writes, timer, flags and read data
  always_comb begin
    nxt_st = st_ff;
    nxt_hold = hold_ff;
    nxt_wide_ctrl = wide_ctrl_ff;
    nxt_st.rdata = 8'h00;
    // register writes
    if (reg_wr_i) begin
      if (reg_addr_i == ADR_UNIT_CTRL) begin
        nxt_st.unit_ctrl = reg_wdata_i[5:0]; // R9
      end else if (reg_addr_i == ADR_DUTY_LOW) begin
        nxt_hold.duty_low = reg_wdata_i;
      end else if (reg_addr_i == ADR_DUTY_SHADOW) begin
        // shadow is read-only while the unit runs pwm
        if (!pwm_mode) begin
          nxt_hold.shadow_hi = reg_wdata_i;
        end
      end else if (reg_addr_i == ADR_PERIOD) begin
        nxt_st.period_reg = reg_wdata_i;
      end else if (reg_addr_i == ADR_PERIOD_CTRL) begin
        nxt_st.t2_ctrl = reg_wdata_i[6:0]; // R11
        nxt_st.post_cnt = 4'h0;
      end else if (reg_addr_i == ADR_PERIOD_COUNT) begin
        nxt_st.t2_count = reg_wdata_i;
      end else if (reg_addr_i == ADR_WIDE_CTRL) begin
        nxt_wide_ctrl = reg_wdata_i;
      end else if (reg_addr_i == ADR_WIDE_LOW) begin
        nxt_hold.wide_lo = reg_wdata_i;
      end else if (reg_addr_i == ADR_WIDE_HIGH) begin
        nxt_hold.wide_hi = reg_wdata_i;
      end else if (reg_addr_i == ADR_FLAGS_ONE) begin
        nxt_st.flags_one = reg_wdata_i;
      end else if (reg_addr_i == ADR_ENABLE_ONE) begin
        nxt_st.enable_one = reg_wdata_i;
      end else if (reg_addr_i == ADR_FLAGS_TWO) begin
        nxt_st.flags_two = reg_wdata_i & FLAGS_TWO_MASK; // R16
      end else if (reg_addr_i == ADR_ENABLE_TWO) begin
        nxt_st.enable_two = reg_wdata_i & FLAGS_TWO_MASK; // R16
      end else if (reg_addr_i == ADR_PORT_C_DIR) begin
        nxt_st.dir_c = reg_wdata_i;
      end else if (reg_addr_i == ADR_PORT_D_DIR) begin
        nxt_st.dir_d = reg_wdata_i;
      end else if (reg_addr_i == ADR_INT_CTRL) begin
        nxt_st.int_ctrl = reg_wdata_i;
      end else if (reg_addr_i == ADR_CMP_CTRL) begin
        nxt_st.cmp_ctrl = reg_wdata_i[1:0];
      end
    end
    // period timer step and wrap
    if (pre_inc && !wr_count) begin
      if (t2_match) begin
        nxt_st.t2_count = 8'h00; // R17
      end else begin
        nxt_st.t2_count = st_ff.t2_count + 8'h01;
      end
    end
    // postscaler counts period matches
    if (reload && !pre_clr) begin
      if (match_evt) begin
        nxt_st.post_cnt = 4'h0;
      end else begin
        nxt_st.post_cnt = st_ff.post_cnt + 4'h1;
      end
    end
    // duty double buffer loads at period start
    if (reload && pwm_mode) begin
      nxt_hold.shadow_hi = hold_ff.duty_low; // R17
      nxt_hold.shadow_lo = st_ff.unit_ctrl[5:DUTY_LO_POS];
    end
    // reads, with read-to-clear of the flag registers
    if (reg_rd_i) begin
      if (reg_addr_i == ADR_UNIT_CTRL) begin
        nxt_st.rdata = {2'b00, st_ff.unit_ctrl}; // R9
      end else if (reg_addr_i == ADR_DUTY_LOW) begin
        nxt_st.rdata = hold_ff.duty_low;
      end else if (reg_addr_i == ADR_DUTY_SHADOW) begin
        nxt_st.rdata = hold_ff.shadow_hi;
      end else if (reg_addr_i == ADR_PERIOD) begin
        nxt_st.rdata = st_ff.period_reg;
      end else if (reg_addr_i == ADR_PERIOD_CTRL) begin
        nxt_st.rdata = {1'b0, st_ff.t2_ctrl}; // R11
      end else if (reg_addr_i == ADR_PERIOD_COUNT) begin
        nxt_st.rdata = st_ff.t2_count;
      end else if (reg_addr_i == ADR_WIDE_CTRL) begin
        nxt_st.rdata = wide_ctrl_ff;
      end else if (reg_addr_i == ADR_WIDE_LOW) begin
        nxt_st.rdata = hold_ff.wide_lo;
      end else if (reg_addr_i == ADR_WIDE_HIGH) begin
        nxt_st.rdata = hold_ff.wide_hi;
      end else if (reg_addr_i == ADR_FLAGS_ONE) begin
        nxt_st.rdata = st_ff.flags_one;
        nxt_st.flags_one = 8'h00;
      end else if (reg_addr_i == ADR_ENABLE_ONE) begin
        nxt_st.rdata = st_ff.enable_one;
      end else if (reg_addr_i == ADR_FLAGS_TWO) begin
        nxt_st.rdata = st_ff.flags_two;
        nxt_st.flags_two = 8'h00;
      end else if (reg_addr_i == ADR_ENABLE_TWO) begin
        nxt_st.rdata = st_ff.enable_two;
      end else if (reg_addr_i == ADR_PORT_C_DIR) begin
        nxt_st.rdata = st_ff.dir_c;
      end else if (reg_addr_i == ADR_PORT_D_DIR) begin
        nxt_st.rdata = st_ff.dir_d;
      end else if (reg_addr_i == ADR_INT_CTRL) begin
        nxt_st.rdata = st_ff.int_ctrl;
      end else if (reg_addr_i == ADR_CMP_CTRL) begin
        nxt_st.rdata = {6'h00, st_ff.cmp_ctrl};
      end else begin
        nxt_st.rdata = 8'h00;
      end
    end
    // hardware set wins over clear by read or write
    if (match_evt) begin
      nxt_st.flags_one[FLAG_MATCH] = 1'b1; // R16 R8
    end
  end

  // any reset: control, count, flags and directions
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_ff.unit_ctrl <= RST_UNIT_CTRL; // R1 R9
      st_ff.period_reg <= RST_PERIOD;
      st_ff.t2_ctrl <= RST_PERIOD_CTRL; // R11
      st_ff.t2_count <= RST_BYTE; // R14
      st_ff.post_cnt <= 4'h0;
      st_ff.flags_one <= RST_BYTE; // R16
      st_ff.enable_one <= RST_BYTE; // R16
      st_ff.flags_two <= RST_BYTE; // R16
      st_ff.enable_two <= RST_BYTE; // R16
      st_ff.dir_c <= RST_DIR; // R15
      st_ff.dir_d <= RST_DIR; // R15
      st_ff.int_ctrl <= RST_BYTE;
      st_ff.cmp_ctrl <= RST_CMP_CTRL;
      st_ff.rdata <= RST_BYTE;
    end else if (ce_i) begin
      st_ff <= nxt_st;
    end
  end

  // power-on only: wide timer control
  always_ff @(posedge core_clk_i or negedge npor_i) begin
    if (!npor_i) begin
      wide_ctrl_ff <= RST_BYTE; // R12
    end else if (ce_i) begin
      wide_ctrl_ff <= nxt_wide_ctrl;
    end
  end

  // unknown at power-on, untouched by later resets
  always_ff @(posedge core_clk_i) begin
    if (ce_i) begin
      hold_ff <= nxt_hold; // R10 R13
    end
  end

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);

  sequence s_reload;
    ce_i && pwm_mode && reload;
  endsequence

  property p_reload;
    s_reload |=> (st_ff.t2_count == 8'h00)
      && (hold_ff.shadow_hi == $past(hold_ff.duty_low));
  endproperty
  a_reload: assert property (p_reload) // R17
    else $error("period wrap did not clear count or load shadow");

  property p_pin_set;
    s_reload ##0 !duty_zero |=> pwm_level;
  endproperty
  a_pin_set: assert property (p_pin_set) // R17
    else $error("pwm pin not set at period start");

  property p_flag;
    ce_i && match_evt |=> st_ff.flags_one[FLAG_MATCH]
      && (irq_o || !st_ff.enable_one[FLAG_MATCH]);
  endproperty
  a_flag: assert property (p_flag) // R16
    else $error("period match flag not set");

  property p_oe;
    ce_i && reg_wr_i && (reg_addr_i == ADR_PORT_C_DIR)
      && reg_wdata_i[PWM_PIN_BIT] |=> !pwm_pin_oe_o;
  endproperty
  a_oe: assert property (p_oe) // R19
    else $error("pwm pin driven while direction is input");

  property p_ctrl_rd;
    ce_i && reg_rd_i && (reg_addr_i == ADR_UNIT_CTRL)
      |=> (reg_rdata_o[7:6] == 2'b00)
      && (reg_rdata_o[5:0] == $past(st_ff.unit_ctrl));
  endproperty
  a_ctrl_rd: assert property (p_ctrl_rd) // R9
    else $error("unit control read back wrong");

  property p_t2_rd;
    ce_i && reg_rd_i && (reg_addr_i == ADR_PERIOD_CTRL)
      |=> !reg_rdata_o[7];
  endproperty
  a_t2_rd: assert property (p_t2_rd) // R11
    else $error("timer control bit 7 not zero");

  property p_dir_rst;
    $rose(nrst_i) |-> (port_c_oe_o == 8'h00) && (port_d_oe_o == 8'h00)
      && (st_ff.unit_ctrl == RST_UNIT_CTRL);
  endproperty
  a_dir_rst: assert property (p_dir_rst) // R1 R15
    else $error("pins or control not reset");

  property p_cnt_rst;
    $rose(nrst_i) |-> (st_ff.t2_count == 8'h00) && !irq_o;
  endproperty
  a_cnt_rst: assert property (p_cnt_rst) // R14
    else $error("period count not cleared by reset");

  property p_wide_rst;
    $rose(npor_i) |-> wide_ctrl_ff == 8'h00;
  endproperty
  a_wide_rst: assert property (p_wide_rst) // R12
    else $error("wide timer control not cleared at power-on");

endmodule

// ===== core/pws_pkg.sv
package pws_pkg;

  // register addresses on the plain register port
  localparam logic [4:0] ADR_UNIT_CTRL = 5'h00;
  localparam logic [4:0] ADR_DUTY_LOW = 5'h01;
  localparam logic [4:0] ADR_DUTY_SHADOW = 5'h02;
  localparam logic [4:0] ADR_PERIOD = 5'h03;
  localparam logic [4:0] ADR_PERIOD_CTRL = 5'h04;
  localparam logic [4:0] ADR_PERIOD_COUNT = 5'h05;
  localparam logic [4:0] ADR_WIDE_CTRL = 5'h06;
  localparam logic [4:0] ADR_WIDE_LOW = 5'h07;
  localparam logic [4:0] ADR_WIDE_HIGH = 5'h08;
  localparam logic [4:0] ADR_FLAGS_ONE = 5'h09;
  localparam logic [4:0] ADR_ENABLE_ONE = 5'h0a;
  localparam logic [4:0] ADR_FLAGS_TWO = 5'h0b;
  localparam logic [4:0] ADR_ENABLE_TWO = 5'h0c;
  localparam logic [4:0] ADR_PORT_C_DIR = 5'h0d;
  localparam logic [4:0] ADR_PORT_D_DIR = 5'h0e;
  localparam logic [4:0] ADR_INT_CTRL = 5'h0f;
  localparam logic [4:0] ADR_CMP_CTRL = 5'h10;

  // values after reset
  localparam logic [5:0] RST_UNIT_CTRL = 6'h00;
  localparam logic [6:0] RST_PERIOD_CTRL = 7'h00;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_DIR = 8'hff;
  localparam logic [7:0] RST_PERIOD = 8'hff;
  localparam logic [1:0] RST_CMP_CTRL = 2'h2;

  // field positions
  localparam int DUTY_LO_POS = 4;
  localparam int MODE_HI_POS = 2;
  localparam int RUN_POS = 2;
  localparam int POST_POS = 3;
  localparam int FLAG_UNIT_ONE = 2;
  localparam int FLAG_MATCH = 1;
  localparam int FLAG_UNIT_TWO = 0;
  localparam logic [7:0] FLAGS_TWO_MASK = 8'hf5;

  // encodings
  localparam logic [1:0] MODE_PWM = 2'h3;
  localparam logic [1:0] PRE_DIV1 = 2'h0;
  localparam logic [1:0] PRE_DIV4 = 2'h1;

  // clocks per timer step at each prescale, minus one
  localparam logic [5:0] PRE_LAST_1 = 6'h03;
  localparam logic [5:0] PRE_LAST_4 = 6'h0f;
  localparam logic [5:0] PRE_LAST_16 = 6'h3f;

endpackage

// ===== core/pws_prescaler.sv
`timescale 1ns/10ps
module pws_prescaler
  import pws_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // control
  input wire logic run_i,
  input wire logic clr_i,
  input wire logic [1:0] sel_i,
  // time base outputs
  output logic [1:0] frac_o,
  output logic inc_o
);

  typedef struct packed {
    logic [5:0] cnt;
  } pws_pre_st_t;

  pws_pre_st_t st_ff;
  pws_pre_st_t nxt_st;
  logic [5:0] last;

  // terminal count for the chosen ratio
  always_comb begin
    if (sel_i == PRE_DIV1) begin
      last = PRE_LAST_1;
    end else if (sel_i == PRE_DIV4) begin
      last = PRE_LAST_4;
    end else begin
      last = PRE_LAST_16;
    end
    inc_o = run_i && !clr_i && (st_ff.cnt >= last);
  end

  // counter holds while stopped, restarts on clear
  // fine bits come from the next count so the pin flop lands on time
  always_comb begin
    nxt_st = st_ff;
    if (clr_i) begin
      nxt_st.cnt = 6'h00;
    end else if (run_i) begin
      nxt_st.cnt = inc_o ? 6'h00 : st_ff.cnt + 6'h01;
    end
    if (sel_i == PRE_DIV1) begin
      frac_o = nxt_st.cnt[1:0];
    end else if (sel_i == PRE_DIV4) begin
      frac_o = nxt_st.cnt[3:2];
    end else begin
      frac_o = nxt_st.cnt[5:4];
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_ff <= '0;
    end else if (ce_i) begin
      st_ff <= nxt_st;
    end
  end

  property p_inc_gap;
    @(posedge core_clk_i) disable iff (!nrst_i)
      ce_i && inc_o |=> !inc_o;
  endproperty
  a_inc_gap: assert property (p_inc_gap)
    else $error("prescaler step pulses back to back");

endmodule

// ===== core/pws_pwm_out.sv
`timescale 1ns/10ps
module pws_pwm_out
  import pws_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // control from the timer
  input wire logic en_i,
  input wire logic reload_i,
  input wire logic duty_zero_i,
  input wire logic [9:0] base_i,
  input wire logic [9:0] duty_i,
  // waveform
  output logic level_o
);

  typedef struct packed {
    logic level;
  } pws_out_st_t;

  pws_out_st_t st_ff;
  pws_out_st_t nxt_st;

  assign level_o = st_ff.level;

  // set at period start, clear at duty match
  always_comb begin
    nxt_st = st_ff;
    if (!en_i) begin
      nxt_st.level = 1'b0;
    end else if (reload_i) begin
      nxt_st.level = !duty_zero_i; // R17
    end else if (base_i == duty_i) begin
      nxt_st.level = 1'b0; // R18
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_ff <= '0;
    end else if (ce_i) begin
      st_ff <= nxt_st;
    end
  end

  property p_pin_clr;
    @(posedge core_clk_i) disable iff (!nrst_i)
      ce_i && en_i && !reload_i && (base_i == duty_i) |=> !level_o;
  endproperty
  a_pin_clr: assert property (p_pin_clr) // R18
    else $error("pwm level not cleared at duty match");

endmodule

// ===== dv/tb_top.sv
`timescale 1ns/10ps
module tb_top
  import pws_pkg::*;
;
  // clock, resets and enable
  logic core_clk_i;
  logic nrst_i;
  logic npor_i;
  logic ce_i;
  // register port
  logic [4:0] reg_addr_i;
  logic [7:0] reg_wdata_i;
  logic reg_wr_i;
  logic reg_rd_i;
  logic [7:0] reg_rdata_o;
  // pins and interrupt
  logic pwm_pin_o;
  logic pwm_pin_oe_o;
  logic [7:0] port_c_oe_o;
  logic [7:0] port_d_oe_o;
  logic irq_o;
  // bench bookkeeping
  int errors;
  int n_compared;
  int cycles;
  int n;

  pws_top #(.PWM_PIN_BIT(2)) i_pws_top (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .npor_i(npor_i),
    .ce_i(ce_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o),
    .pwm_pin_o(pwm_pin_o),
    .pwm_pin_oe_o(pwm_pin_oe_o),
    .port_c_oe_o(port_c_oe_o),
    .port_d_oe_o(port_d_oe_o),
    .irq_o(irq_o)
  );

  // 100 mhz clock
  initial begin
    core_clk_i = 1'b0;
  end
  always #5 core_clk_i = ~core_clk_i;

  // verdict and end of run
  task automatic complete_run();
    if (errors == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      complete_run();
    end
  end

  // compare seen against expected
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask

  // one-cycle read strobe, data taken in the following cycle
  task automatic rdchk(input logic [4:0] a, input logic [7:0] exp);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    check(reg_rdata_o, exp);
  endtask

  // reset pulse, power-on flavour when por is set
  task automatic pulse_reset(input logic por);
    @(posedge core_clk_i);
    nrst_i <= 1'b0;
    npor_i <= ~por;
    repeat (3) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    npor_i <= 1'b1;
  endtask

  // count high cycles of the waveform over one period of len clocks
  task automatic count_high(input int len);
    n = 0;
    repeat (len) begin
      @(posedge core_clk_i);
      #1;
      if (pwm_pin_o === 1'b1) n = n + 1;
    end
  endtask

  // main sequence
  initial begin
    nrst_i = 1'b0;
    npor_i = 1'b0;
    ce_i = 1'b1;
    reg_addr_i = 5'h00;
    reg_wdata_i = 8'h00;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    errors = 0;
    n_compared = 0;
    cycles = 0;
    repeat (20) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    npor_i <= 1'b1;
    #1;
    // values after power-on
    check(port_c_oe_o, 8'h00);
    check(port_d_oe_o, 8'h00);
    check({7'h00, pwm_pin_oe_o}, 8'h00);
    check({7'h00, irq_o}, 8'h00);
    rdchk(ADR_UNIT_CTRL, 8'h00);
    rdchk(ADR_PERIOD_CTRL, 8'h00);
    rdchk(ADR_PERIOD_COUNT, 8'h00);
    rdchk(ADR_WIDE_CTRL, 8'h00);
    rdchk(ADR_FLAGS_ONE, 8'h00);
    rdchk(ADR_ENABLE_ONE, 8'h00);
    rdchk(ADR_FLAGS_TWO, 8'h00);
    rdchk(ADR_ENABLE_TWO, 8'h00);
    rdchk(ADR_PORT_C_DIR, 8'hff);
    rdchk(ADR_PORT_D_DIR, 8'hff);
    rdchk(ADR_CMP_CTRL, 8'h02);
    rdchk(ADR_PERIOD, 8'hff);
    rdchk(ADR_INT_CTRL, 8'h00);
    // unimplemented bits read zero
    wr(ADR_UNIT_CTRL, 8'hff);
    rdchk(ADR_UNIT_CTRL, 8'h3f);
    wr(ADR_UNIT_CTRL, 8'h00);
    wr(ADR_PERIOD_CTRL, 8'hff);
    rdchk(ADR_PERIOD_CTRL, 8'h7f);
    wr(ADR_PERIOD_CTRL, 8'h00);
    wr(ADR_ENABLE_TWO, 8'hff);
    rdchk(ADR_ENABLE_TWO, 8'hf5);
    wr(ADR_ENABLE_TWO, 8'h00);
    // unmapped place and frozen clock enable
    wr(5'h1f, 8'haa);
    rdchk(5'h1f, 8'h00);
    @(posedge core_clk_i) ce_i <= 1'b0;
    wr(ADR_ENABLE_TWO, 8'h01);
    @(posedge core_clk_i) ce_i <= 1'b1;
    rdchk(ADR_ENABLE_TWO, 8'h00);
    // interrupt raised, masked, cleared by read
    wr(ADR_ENABLE_ONE, 8'h02);
    wr(ADR_FLAGS_ONE, 8'h02);
    check({7'h00, irq_o}, 8'h01);
    wr(ADR_ENABLE_ONE, 8'h00);
    check({7'h00, irq_o}, 8'h00);
    wr(ADR_ENABLE_ONE, 8'h02);
    rdchk(ADR_FLAGS_ONE, 8'h02);
    check({7'h00, irq_o}, 8'h00);
    wr(ADR_ENABLE_TWO, 8'h01);
    wr(ADR_FLAGS_TWO, 8'hff);
    check({7'h00, irq_o}, 8'h01);
    rdchk(ADR_FLAGS_TWO, 8'hf5);
    check({7'h00, irq_o}, 8'h00);
    wr(ADR_ENABLE_TWO, 8'h00);
    // pwm bring-up: driver off, period, mode, duty 6, start
    wr(ADR_PORT_C_DIR, 8'hff);
    wr(ADR_PERIOD, 8'h03);
    wr(ADR_UNIT_CTRL, 8'h2c);
    wr(ADR_DUTY_LOW, 8'h01);
    wr(ADR_FLAGS_ONE, 8'h00);
    wr(ADR_PERIOD_CTRL, 8'h00);
    wr(ADR_PERIOD_CTRL, 8'h04);
    n = 0;
    while (irq_o !== 1'b1 && n < 100) begin
      @(posedge core_clk_i);
      #1;
      n = n + 1;
    end
    check({7'h00, irq_o}, 8'h01);
    check({7'h00, pwm_pin_oe_o}, 8'h00);
    rdchk(ADR_DUTY_SHADOW, 8'h01);
    wr(ADR_PORT_C_DIR, 8'hfb);
    check({7'h00, pwm_pin_oe_o}, 8'h01);
    check(port_c_oe_o, 8'h04);
    count_high(16);
    check(8'(n), 8'h06);
    // divide-by-four prescale stretches period and pulse
    wr(ADR_PERIOD_CTRL, 8'h05);
    repeat (70) @(posedge core_clk_i);
    count_high(64);
    check(8'(n), 8'h18);
    wr(ADR_PERIOD_CTRL, 8'h04);
    // zero duty never sets the pin
    wr(ADR_DUTY_LOW, 8'h00);
    wr(ADR_UNIT_CTRL, 8'h0c);
    repeat (40) @(posedge core_clk_i);
    count_high(16);
    check(8'(n), 8'h00);
    rdchk(ADR_DUTY_SHADOW, 8'h00);
    // warm reset keeps some registers, resets the rest
    wr(ADR_PERIOD_CTRL, 8'h00);
    wr(ADR_PERIOD_COUNT, 8'h02);
    rdchk(ADR_PERIOD_COUNT, 8'h02);
    wr(ADR_DUTY_LOW, 8'h5c);
    wr(ADR_WIDE_LOW, 8'h33);
    wr(ADR_WIDE_HIGH, 8'hc3);
    wr(ADR_WIDE_CTRL, 8'h5a);
    pulse_reset(1'b0);
    #1;
    check(port_c_oe_o, 8'h00);
    check({7'h00, pwm_pin_oe_o}, 8'h00);
    rdchk(ADR_PERIOD_COUNT, 8'h00);
    rdchk(ADR_DUTY_LOW, 8'h5c);
    rdchk(ADR_WIDE_LOW, 8'h33);
    rdchk(ADR_WIDE_HIGH, 8'hc3);
    rdchk(ADR_WIDE_CTRL, 8'h5a);
    rdchk(ADR_UNIT_CTRL, 8'h00);
    rdchk(ADR_PORT_C_DIR, 8'hff);
    rdchk(ADR_PERIOD, 8'hff);
    // power-on reset clears the wide timer control
    pulse_reset(1'b1);
    rdchk(ADR_WIDE_CTRL, 8'h00);
    rdchk(ADR_PERIOD_CTRL, 8'h00);
    complete_run();
  end
endmodule
